// ==== verilog/irq_vector_map.sv ====
// Interrupt vector and wakeup map with memory-mapped core, priority and debug registers.
//
// Contract
// [RQ1] Touch event is IRQ 2 at 0x8010; wakes from Active-halt and Wait, never Halt.
// [RQ2] Touch wakes Active-halt only if the unit was active at halt entry.
// [RQ3] Auto-wakeup is IRQ 4 at 0x8018; wakes from Active-halt and Wait, never Halt.
// [RQ4] Port B, D are IRQ 6, 7; lines 0-7 are 8-15; all wake from every mode.
// [RQ5] Eight priority bytes at 0x7F70-0x7F77, each resetting to 0xFF.
// [RQ6] Breakpoint 1 extended, high, low bytes from 0x7F90, reset 0xFF.
// [RQ7] Breakpoint 2 bytes follow at 0x7F93, reset 0xFF.
// [RQ8] Core working registers are memory-mapped bytes from 0x7F00.
// [RQ9] Range 0x7F0B to 0x7F5F holds no register and is reserved.
// [RQ10] I2C wakes from Halt or Active-halt only on own address match.
// [RQ11] In wait-for-event, serve and return, unless source is a wakeup event.
// [RQ12] Reset fetches 0x8000 and ends any low-power mode; trap uses 0x8004.
//
// Implementation choice: the AHB-Lite register port.
`default_nettype none
module irq_vector_map
  import irq_map_pkg::*;
(
  input  wire logic               ref_clk_i,        // 25 MHz clock
  input  wire logic               resetn_i,         // Async reset, active low
  input  wire logic               hsel_i,           // AHB slave select
  input  wire logic [31:0]        haddr_i,          // AHB byte address
  input  wire logic [1:0]         htrans_i,         // AHB transfer type
  input  wire logic               hwrite_i,         // AHB write
  input  wire logic [2:0]         hsize_i,          // AHB size, word only
  input  wire logic [31:0]        hwdata_i,         // AHB write data
  input  wire logic               hready_i,         // AHB bus ready
  output logic      [31:0]        hrdata_o,         // AHB read data
  output logic                    hreadyout_o,      // AHB slave ready
  output logic                    hresp_o,          // AHB response, always OKAY
  input  wire logic [NUM_IRQ-1:0] src_irq_i,        // On-chip source requests
  input  wire logic [NUM_EXT-1:0] ext_pin_i,        // External interrupt pins
  input  wire logic [2:0]         power_mode_i,     // Core low-power mode
  input  wire logic               touch_active_i,   // Touch unit running
  input  wire logic               i2c_addr_match_i, // I2C own address matched
  input  wire logic               irq_ack_i,        // Core takes irq_num_o
  input  wire logic               trap_i,           // Software trap executed
  output logic                    irq_req_o,        // Request to the core
  output logic      [4:0]         irq_num_o,        // Granted interrupt number
  output logic      [23:0]        vector_o,         // Fetch address for the core
  output logic                    irq_o,            // Level interrupt output
  output logic                    wake_o,           // Wake and serve pulse
  output logic                    wake_resume_o     // Wake-event resume pulse
);
  logic [NUM_EXT-1:0] ext_level;
  logic [NUM_IRQ-1:0] wake_allow;
  logic [NUM_IRQ-1:0] src_all;

  logic [7:0]         regs      [REG_COUNT];
  logic [7:0]         next_regs [REG_COUNT];
  logic [NUM_IRQ-1:0] status;
  logic [NUM_IRQ-1:0] next_status;
  logic [NUM_IRQ-1:0] mask;
  logic [NUM_IRQ-1:0] next_mask;
  logic [NUM_IRQ-1:0] event_cfg;
  logic [NUM_IRQ-1:0] next_event_cfg;

  logic               wr_pend;
  logic               next_wr_pend;
  logic               rd_pend;
  logic               next_rd_pend;
  logic [15:0]        dp_idx;
  logic [15:0]        next_dp_idx;
  logic [31:0]        next_hrdata;

  logic               next_irq_req;
  logic [4:0]         next_irq_num;
  logic [23:0]        next_vector;
  logic               touch_armed;
  logic               next_touch_armed;
  logic [2:0]         mode_q;
  logic               wake_lvl;
  logic               next_wake_lvl;
  logic               resume_lvl;
  logic               next_resume_lvl;
  logic               next_wake;
  logic               next_resume;

  logic [NUM_IRQ-1:0] active;
  logic [4:0]         best_num;
  logic [1:0]         best_lvl;
  logic               best_ok;
  logic [1:0]         lvl;
  logic [7:0]         prio_byte;

  irq_pin_sync u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .pin_i     (ext_pin_i),
    .level_o   (ext_level)
  );

  irq_wake_filter u_wake_filter (
    .mode_i        (power_mode_i),
    .touch_armed_i (touch_armed),
    .i2c_match_i   (i2c_addr_match_i),
    .allow_o       (wake_allow)
  );

  // External pins replace the on-chip request lines for IRQ 6 to 15.
  always_comb
  begin
    src_all = src_irq_i;
    src_all[EXT_BASE +: NUM_EXT] = ext_level;     // [RQ4]
  end

  // Bus slave: writes take no wait state; reads take one so that the
  // returned byte already reflects a write of the previous transfer.
  always_comb
  begin
    next_wr_pend = 1'b0;
    next_rd_pend = 1'b0;
    next_dp_idx  = dp_idx;
    if (hsel_i && hready_i && htrans_i == HTRANS_NSEQ)
    begin
      next_wr_pend = hwrite_i;
      next_rd_pend = !hwrite_i;
      next_dp_idx  = haddr_i[17:2];
    end
    else if (rd_pend)
    begin
      next_rd_pend = 1'b0;
    end
  end

  assign hreadyout_o = !rd_pend;
  assign hresp_o     = 1'b0;

  // Byte registers: the core's working set, configuration, priority and debug.
  for (genvar r = 0; r < REG_COUNT; r++)
  begin : g_reg
    always_comb
    begin
      next_regs[r] = regs[r];
      if (wr_pend && dp_idx == REG_IDX[r])
      begin
        next_regs[r] = hwdata_i[7:0];           // [RQ5] [RQ6] [RQ7] [RQ8]
      end
    end
  end

  // Read mux; the reserved window and unmapped indices read as zero.
  always_comb
  begin
    next_hrdata = hrdata_o;
    if (rd_pend)
    begin
      next_hrdata = 32'h0000_0000;
      for (int i = 0; i < REG_COUNT; i++)
      begin
        if (dp_idx == REG_IDX[i])
        begin
          next_hrdata = {24'h00_0000, regs[i]};  // [RQ8]
        end
      end
      if (dp_idx >= RSV_LO_IDX && dp_idx <= RSV_HI_IDX)
      begin
        next_hrdata = 32'h0000_0000;            // [RQ9]
      end
      unique case (dp_idx)
        STATUS_IDX: next_hrdata = {2'h0, status};
        MASK_IDX:   next_hrdata = {2'h0, mask};
        EVENT_IDX:  next_hrdata = {2'h0, event_cfg};
        VECTOR_IDX: next_hrdata = {3'h0, irq_num_o, vector_o};
        default:    ;
      endcase
    end
  end

  // Sticky status: a source sets its bit; software clears by writing one,
  // the core clears by acknowledging. A new request wins over either clear.
  always_comb
  begin
    next_status    = status;
    next_mask      = mask;
    next_event_cfg = event_cfg;
    if (wr_pend && dp_idx == STATUS_IDX)
    begin
      next_status = status & ~hwdata_i[NUM_IRQ-1:0];
    end
    if (irq_ack_i && irq_req_o)
    begin
      next_status[irq_num_o] = 1'b0;
    end
    next_status = (next_status | src_all) & WAKE_WAIT;
    if (wr_pend && dp_idx == MASK_IDX)
    begin
      next_mask = hwdata_i[NUM_IRQ-1:0] & WAKE_WAIT;
    end
    if (wr_pend && dp_idx == EVENT_IDX)
    begin
      next_event_cfg = hwdata_i[NUM_IRQ-1:0] & WAKE_WAIT;
    end
  end

  assign active = status & mask;

  // Highest software level wins; on a tie the lower number wins.
  // The priority bytes hold four 2-bit fields, low source in the low bits.
  always_comb
  begin
    best_num  = 5'h00;
    best_lvl  = 2'h0;
    best_ok   = 1'b0;
    lvl       = 2'h0;
    prio_byte = 8'h00;
    for (int n = 0; n < NUM_IRQ; n++)
    begin
      prio_byte = regs[PRIO_SLOT + n / 4];        // [RQ5]
      lvl       = prio_byte[2 * (n % 4) +: 2];
      if (active[n] && (!best_ok || lvl > best_lvl))
      begin
        best_ok  = 1'b1;
        best_lvl = lvl;
        best_num = 5'(n);
      end
    end
  end

  // Fetch address: reset vector after reset, trap slot, then the grant.
  always_comb
  begin
    next_irq_req = best_ok;
    next_irq_num = best_num;
    next_vector  = vector_o;
    if (trap_i)
    begin
      next_vector = TRAP_VECTOR;                  // [RQ12]
    end
    else if (best_ok)
    begin
      next_vector = IRQ_VEC_BASE + {17'h0_0000, best_num, 2'b00}; // [RQ1] [RQ3] [RQ4]
    end
  end

  // The touch qualifier is caught on each step into active-halt, from any other mode.
  always_comb
  begin
    next_touch_armed = touch_armed;
    if (power_mode_i == MODE_AHALT && mode_q != MODE_AHALT)
    begin
      next_touch_armed = touch_active_i;          // [RQ2]
    end
    else if (power_mode_i != MODE_AHALT)
    begin
      next_touch_armed = 1'b0;
    end
  end

  // Wake pulses fire once per rise of the combined level of all qualifying pending sources.
  always_comb
  begin
    next_resume_lvl = power_mode_i == MODE_WFE && |(active & wake_allow & event_cfg);  // [RQ11]
    next_wake_lvl   = |(active & wake_allow) && !next_resume_lvl;
    next_wake       = next_wake_lvl && !wake_lvl;
    next_resume     = next_resume_lvl && !resume_lvl;                                  // [RQ11]
  end

  assign irq_o = |active;

  // Bus slave state and the registered read data.
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_pend  <= 1'b0;
      rd_pend  <= 1'b0;
      dp_idx   <= 16'h0000;
      hrdata_o <= 32'h0000_0000;
    end
    else
    begin
      wr_pend  <= next_wr_pend;
      rd_pend  <= next_rd_pend;
      dp_idx   <= next_dp_idx;
      hrdata_o <= next_hrdata;
    end
  end

  // Byte registers.
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs[i] <= REG_RST[i];                    // [RQ5] [RQ6] [RQ7] [RQ8]
      end
    end
    else
    begin
      regs <= next_regs;
    end
  end

  // Status, mask and wakeup-event configuration.
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      status    <= STATUS_RST;
      mask      <= MASK_RST;
      event_cfg <= EVENT_RST;
    end
    else
    begin
      status    <= next_status;
      mask      <= next_mask;
      event_cfg <= next_event_cfg;
    end
  end

  // Grant towards the core.
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_req_o <= 1'b0;
      irq_num_o <= 5'h00;
      vector_o  <= RESET_VECTOR;                  // [RQ12]
    end
    else
    begin
      irq_req_o <= next_irq_req;
      irq_num_o <= next_irq_num;
      vector_o  <= next_vector;
    end
  end

  // Low-power mode tracking and wake pulses.
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      touch_armed   <= 1'b0;
      mode_q        <= MODE_RUN;
      wake_lvl      <= 1'b0;
      resume_lvl    <= 1'b0;
      wake_o        <= 1'b0;
      wake_resume_o <= 1'b0;
    end
    else
    begin
      touch_armed   <= next_touch_armed;
      mode_q        <= power_mode_i;
      wake_lvl      <= next_wake_lvl;
      resume_lvl    <= next_resume_lvl;
      wake_o        <= next_wake;
      wake_resume_o <= next_resume;
    end
  end
endmodule // irq_vector_map
`default_nettype wire

// ==== verilog/irq_map_pkg.sv ====
// Constants, register map and types of the interrupt vector and wakeup map.
`default_nettype none
package irq_map_pkg;
  localparam int        NUM_IRQ    = 30;
  localparam int        NUM_EXT    = 10;
  localparam int        EXT_BASE   = 6;
  localparam int        REG_COUNT  = 32;
  localparam int        PRIO_SLOT  = 12;
  localparam int        PRIO_COUNT = 8;
  localparam logic [4:0] TOUCH_IRQ = 5'h02;
  localparam logic [4:0] AWU_IRQ   = 5'h04;
  localparam logic [4:0] I2C_IRQ   = 5'h1D;
  // Register indices; byte address on the bus is four times the index.
  localparam logic [15:0] REG_IDX [REG_COUNT] = '{
    16'h7F00, 16'h7F01, 16'h7F02, 16'h7F03, 16'h7F04, 16'h7F05, 16'h7F06, 16'h7F07,
    16'h7F08, 16'h7F09, 16'h7F0A, 16'h7F60, 16'h7F70, 16'h7F71, 16'h7F72, 16'h7F73,
    16'h7F74, 16'h7F75, 16'h7F76, 16'h7F77, 16'h7F80, 16'h7F90, 16'h7F91, 16'h7F92,
    16'h7F93, 16'h7F94, 16'h7F95, 16'h7F96, 16'h7F97, 16'h7F98, 16'h7F99, 16'h7F9A};
  localparam logic [7:0] REG_RST [REG_COUNT] = '{
    8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h05, 8'hFF, 8'h28, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h10, 8'h00, 8'hFF};
  localparam logic [15:0] RSV_LO_IDX   = 16'h7F0B;
  localparam logic [15:0] RSV_HI_IDX   = 16'h7F5F;
  localparam logic [15:0] STATUS_IDX   = 16'h7FA0;
  localparam logic [15:0] MASK_IDX     = 16'h7FA1;
  localparam logic [15:0] EVENT_IDX    = 16'h7FA2;
  localparam logic [15:0] VECTOR_IDX   = 16'h7FA3;
  localparam logic [29:0] STATUS_RST   = 30'h0000_0000;
  localparam logic [29:0] MASK_RST     = 30'h0000_0000;
  localparam logic [29:0] EVENT_RST    = 30'h0000_0000;
  // Wake permissions per mode; the Wait row also lists every implemented source.
  localparam logic [29:0] WAKE_HALT    = 30'h2400_FFC0;
  localparam logic [29:0] WAKE_AHALT   = 30'h2400_FFD4;
  localparam logic [29:0] WAKE_WAIT    = 30'h3E78_FFD6;
  localparam logic [23:0] RESET_VECTOR = 24'h00_8000;
  localparam logic [23:0] TRAP_VECTOR  = 24'h00_8004;
  localparam logic [23:0] IRQ_VEC_BASE = 24'h00_8008;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  typedef enum logic [2:0] {
    MODE_RUN   = 3'b000,
    MODE_WFI   = 3'b001,
    MODE_WFE   = 3'b010,
    MODE_HALT  = 3'b011,
    MODE_AHALT = 3'b100
  } power_mode_type;
endpackage
`default_nettype wire

// ==== verilog/irq_pin_sync.sv ====
// Three-stage synchroniser for external interrupt pins.
`default_nettype none
module irq_pin_sync
  import irq_map_pkg::*;
(
  input  wire logic               ref_clk_i, // Clock
  input  wire logic               resetn_i,  // Async reset, active low
  input  wire logic [NUM_EXT-1:0] pin_i,     // Raw pin levels
  output logic      [NUM_EXT-1:0] level_o    // Settled levels
);
  logic [NUM_EXT-1:0] stage1;
  logic [NUM_EXT-1:0] stage2;
  logic [NUM_EXT-1:0] stage3;
  logic [NUM_EXT-1:0] next_level;

  for (genvar b = 0; b < NUM_EXT; b++)
  begin : g_bit
    // A change counts only once the last two stages agree.
    always_comb
    begin
      next_level[b] = (stage2[b] == stage3[b]) ? stage3[b] : level_o[b];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stage1  <= '0;
      stage2  <= '0;
      stage3  <= '0;
      level_o <= '0;
    end
    else
    begin
      stage1  <= pin_i;
      stage2  <= stage1;
      stage3  <= stage2;
      level_o <= next_level;
    end
  end
endmodule // irq_pin_sync
`default_nettype wire

// ==== verilog/irq_wake_filter.sv ====
// Per-mode table of the sources allowed to wake the core.
`default_nettype none
module irq_wake_filter
  import irq_map_pkg::*;
(
  input  wire logic [2:0]         mode_i,        // Current low-power mode
  input  wire logic               touch_armed_i, // Touch unit active at halt entry
  input  wire logic               i2c_match_i,   // Own address matched
  output logic      [NUM_IRQ-1:0] allow_o        // Sources allowed to wake
);
  always_comb
  begin
    unique case (mode_i)
      MODE_RUN:   allow_o = '0;
      MODE_WFI,
      MODE_WFE:   allow_o = WAKE_WAIT;       // [RQ1] [RQ3] [RQ4]
      MODE_HALT:  allow_o = WAKE_HALT;       // [RQ1] [RQ3] [RQ4]
      MODE_AHALT: allow_o = WAKE_AHALT;      // [RQ1] [RQ3] [RQ4]
      default:    allow_o = '0;
    endcase
    if (mode_i == MODE_AHALT && !touch_armed_i)
    begin
      allow_o[TOUCH_IRQ] = 1'b0;             // [RQ2]
    end
    if ((mode_i == MODE_HALT || mode_i == MODE_AHALT) && !i2c_match_i)
    begin
      allow_o[I2C_IRQ] = 1'b0;               // [RQ10]
    end
  end
endmodule // irq_wake_filter
`default_nettype wire

// ==== tb/irq_map_monitor.sv ====
// Checker of bus timing, vector mapping and wake pulses of the interrupt map.
`default_nettype none
module irq_map_monitor
  import irq_map_pkg::*;
(
  input wire logic        ref_clk_i,    // Clock
  input wire logic        resetn_i,     // Reset, active low
  input wire logic        hsel_i,       // Select
  input wire logic [1:0]  htrans_i,     // Transfer type
  input wire logic        hwrite_i,     // Write
  input wire logic        hready_i,     // Bus ready
  input wire logic        hreadyout_o,  // Slave ready
  input wire logic        hresp_o,      // Response
  input wire logic        trap_i,       // Trap executed
  input wire logic        irq_req_o,    // Request to core
  input wire logic [4:0]  irq_num_o,    // Winner
  input wire logic [23:0] vector_o,     // Fetch address
  input wire logic        irq_o,        // Level interrupt
  input wire logic        wake_o,       // Wake pulse
  input wire logic        wake_resume_o // Resume pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence rd_take_s;
    hsel_i && hready_i && htrans_i == HTRANS_NSEQ && !hwrite_i;
  endsequence
  sequence wr_take_s;
    hsel_i && hready_i && htrans_i == HTRANS_NSEQ && hwrite_i;
  endsequence
  sequence rd_wait_s;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  a_resp_always_okay: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  a_read_one_wait: assert property (rd_take_s |=> rd_wait_s)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (wr_take_s |=> hreadyout_o)
    else $error("write stalled");
  a_vector_of_num: assert property (irq_req_o && !$past(trap_i) |->
    vector_o == IRQ_VEC_BASE + {17'h0, irq_num_o, 2'h0})
    else $error("vector does not match number");
  a_trap_vector: assert property (trap_i |=> vector_o == TRAP_VECTOR)
    else $error("trap vector wrong");
  a_request_follows: assert property ($rose(irq_o) |=> irq_req_o)
    else $error("request late");
  a_no_reserved_num: assert property (irq_req_o |->
    !(irq_num_o inside {5'd0, 5'd3, 5'd5, 5'd16, 5'd17, 5'd18, 5'd23, 5'd24}))
    else $error("reserved number granted");
  a_wake_one_cycle: assert property (wake_o |=> !wake_o)
    else $error("wake pulse too long");
  a_wake_kinds_apart: assert property (!(wake_o && wake_resume_o))
    else $error("both wake kinds at once");
endmodule // irq_map_monitor

bind irq_vector_map irq_map_monitor i_irq_map_monitor (.ref_clk_i, .resetn_i, .hsel_i, .htrans_i,
  .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .trap_i, .irq_req_o, .irq_num_o, .vector_o, .irq_o,
  .wake_o, .wake_resume_o);
`default_nettype wire

// ==== tb/core_model.sv ====
// Behavioural core that takes granted interrupts and executes traps.
`default_nettype none
module core_model #(
  parameter int ACK_DELAY = 3
) (
  input  wire logic ref_clk_i,  // Clock
  input  wire logic resetn_i,   // Reset, active low
  input  wire logic irq_req_i,  // Request from the map
  input  wire logic trap_cmd_i, // Bench asks for a trap
  output logic      irq_ack_o,  // Takes the granted number
  output logic      trap_o      // Trap executed
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;
  // A real core reaches an instruction boundary first, so it never takes at once.
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      wait_cnt  <= 0;
      irq_ack_o <= 1'b0;
      trap_o    <= 1'b0;
    end
    else
    begin
      trap_o    <= trap_cmd_i;
      irq_ack_o <= irq_req_i && wait_cnt == ACK_DELAY;
      if (!irq_req_i || wait_cnt == ACK_DELAY)
        wait_cnt <= 0;
      else
        wait_cnt <= wait_cnt + 1;
    end
endmodule // core_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the interrupt vector and wakeup map.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_map_pkg::*;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [29:0] src = 30'h0;
  logic [9:0]  ext = 10'h0;
  logic [2:0]  mode = MODE_RUN;
  logic        touch = 1'b0;
  logic        i2c_match = 1'b0;
  logic        trap_cmd = 1'b0;
  logic [31:0] hrdata;
  logic        hready;
  logic        ack;
  logic        trap;
  logic        irq_req;
  logic [4:0]  irq_num;
  logic [23:0] vector;
  logic        irq;
  logic        wake;
  logic        resume;
  logic [31:0] rv;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles = 0;

  initial
    forever #20 ref_clk = ~ref_clk;

  irq_vector_map i_irq_vector_map (.ref_clk_i(ref_clk), .resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .src_irq_i(src), .ext_pin_i(ext),
    .power_mode_i(mode), .touch_active_i(touch), .i2c_addr_match_i(i2c_match), .irq_ack_i(ack),
    .trap_i(trap), .irq_req_o(irq_req), .irq_num_o(irq_num), .vector_o(vector), .irq_o(irq),
    .wake_o(wake), .wake_resume_o(resume));
  core_model i_core_model (.ref_clk_i(ref_clk), .resetn_i(resetn), .irq_req_i(irq_req),
    .trap_cmd_i(trap_cmd), .irq_ack_o(ack), .trap_o(trap));

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single word transfer; read data lands in rv at the completing edge.
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NSEQ;
    hwrite <= wr;
    haddr <= {14'h0, idx, 2'h0};
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rv = hrdata;
  endtask

  task automatic do_reset;
    resetn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk("reset vector", {8'h0, vector}, 32'h0000_8000);
    resetn <= 1'b1;
  endtask

  // Flags are touch active, address match, wakeup event, expected wake, expected resume.
  task automatic fire(input int n, input logic [2:0] md, input logic [4:0] f);
    logic       sw = 1'b0;
    logic       sr = 1'b0;
    logic [4:0] num = 5'h0;
    logic [23:0] vec = 24'h0;
    bus(1'b1, MASK_IDX, 32'h1 << n);
    bus(1'b1, EVENT_IDX, {31'h0, f[2]} << n);
    mode <= MODE_RUN;
    touch <= f[4];
    i2c_match <= f[3];
    repeat (2) @(posedge ref_clk);
    mode <= md;
    repeat (2) @(posedge ref_clk);
    if (n >= 6 && n < 16)
      ext <= 10'h1 << (n - 6);
    else
      src <= 30'h1 << n;
    for (int c = 0; c < 20; c++)
    begin
      @(posedge ref_clk);
      if (c == 2)
      begin
        src <= 30'h0;
        ext <= 10'h0;
      end
      sw |= wake;
      sr |= resume;
      if (irq_req === 1'b1 && num == 5'h0)
      begin
        num = irq_num;
        vec = vector;
      end
    end
    chk("irq number", {27'h0, num}, 32'(n));
    chk("vector", {8'h0, vec}, 32'h8008 + 32'(4 * n));
    chk("wake", {31'h0, sw}, {31'h0, f[1]});
    chk("resume", {31'h0, sr}, {31'h0, f[0]});
    chk("served level", {31'h0, irq}, 32'h0);
  endtask

  initial
  begin
    do_reset();
    for (int i = 0; i < REG_COUNT; i++)
    begin
      bus(1'b0, REG_IDX[i], 32'h0);
      chk("reset value", rv, {24'h0, REG_RST[i]});
      bus(1'b1, REG_IDX[i], {24'h0, 8'h5A ^ 8'(i)});
      bus(1'b0, REG_IDX[i], 32'h0);
      chk("readback", rv, {24'h0, 8'h5A ^ 8'(i)});
    end
    for (int a = 'h7F0B; a <= 'h7F5F; a += 42)
    begin
      bus(1'b1, 16'(a), 32'hFF);
      bus(1'b0, 16'(a), 32'h0);
      chk("reserved", rv, 32'h0);
    end
    do_reset();
    bus(1'b0, 16'h7F77, 32'h0);
    chk("priority after reset", rv, 32'hFF);
    $display("test registers done");
    fire(4, MODE_HALT, 5'b00000);
    fire(4, MODE_AHALT, 5'b00010);
    fire(4, MODE_WFI, 5'b00010);
    fire(2, MODE_HALT, 5'b10000);
    fire(2, MODE_AHALT, 5'b10010);
    fire(2, MODE_AHALT, 5'b00000);
    fire(2, MODE_WFE, 5'b00010);
    fire(2, MODE_WFE, 5'b00101);
    for (int n = 6; n < 16; n++)
      fire(n, MODE_HALT, 5'b00010);
    fire(29, MODE_HALT, 5'b00000);
    fire(29, MODE_AHALT, 5'b01010);
    $display("test wakeup done");
    bus(1'b1, MASK_IDX, 32'h0);
    src <= 30'h10;
    @(posedge ref_clk);
    src <= 30'h0;
    repeat (3) @(posedge ref_clk);
    chk("masked level", {31'h0, irq}, 32'h0);
    bus(1'b0, STATUS_IDX, 32'h0);
    chk("sticky status", rv, 32'h10);
    bus(1'b1, STATUS_IDX, 32'h10);
    bus(1'b0, STATUS_IDX, 32'h0);
    chk("cleared status", rv, 32'h0);
    // Two pending sources: a tie goes to the lower number, then a lowered level loses.
    bus(1'b1, MASK_IDX, 32'h14);
    for (int p = 0; p < 2; p++)
    begin
      src <= 30'h14;
      @(posedge ref_clk);
      src <= 30'h0;
      repeat (2) @(posedge ref_clk);
      chk("priority winner", {27'h0, irq_num}, p ? 32'h4 : 32'h2);
      repeat (20) @(posedge ref_clk);
      bus(1'b1, 16'h7F70, 32'hCF);
    end
    bus(1'b0, VECTOR_IDX, 32'h0);
    chk("vector register", rv, 32'h0000_8010);
    trap_cmd <= 1'b1;
    @(posedge ref_clk);
    trap_cmd <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("trap vector", {8'h0, vector}, 32'h0000_8004);
    $display("test status and trap done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
